// ==== hw/hcp_consts.svh ====
/*
  Constants for the two-port hard copy output block: register offsets,
  status word bit positions, configuration field positions and timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef HCP_CONSTS_SVH
`define HCP_CONSTS_SVH

`define HCP_OFS_P1_DATA     4'h6
`define HCP_OFS_P2_DATA     4'h4
`define HCP_OFS_P1_CFG      4'h8
`define HCP_OFS_P2_CFG      4'hA
`define HCP_OFS_STATUS      4'hE

`define HCP_CFG_MASTER_EN   0
`define HCP_CFG_BUSY_EDGE   1
`define HCP_CFG_ACK_EN      2
`define HCP_CFG_DMA_EN      3
`define HCP_CFG_RESET       8'h00
`define HCP_DATA_RESET      8'h00

`define HCP_ST_DMA_IP       0
`define HCP_ST_P1_BASE      1
`define HCP_ST_P2_BASE      8
`define HCP_ST_MIP          15

`define HCP_CLK_HZ          20000000
`define HCP_SETTLE_NS       1000
`define HCP_STROBE_NS       1000
`define HCP_SETTLE_CYC      ((`HCP_SETTLE_NS * (`HCP_CLK_HZ / 1000000)) / 1000)
`define HCP_STROBE_CYC      ((`HCP_STROBE_NS * (`HCP_CLK_HZ / 1000000)) / 1000)

`endif

// ==== hw/hcp_pkg.sv ====
/*
  Types shared by the hard copy port block.
  Assumes the constants header sits beside it.
*/
package hcp_pkg;
  typedef logic [7:0]  hcp_byte_t;
  typedef logic [15:0] hcp_word_t;
  typedef logic [3:0]  hcp_addr_t;
  typedef enum logic [2:0]
  {
    HCP_IDLE   = 3'b001,
    HCP_SETTLE = 3'b010,
    HCP_STROBE = 3'b100
  } hcp_state_e;
endpackage

// ==== hw/hcp_top.sv ====
/*
  Two independent parallel hard copy output ports with data latch, strobe
  timer, read-back, per-port configuration and the interface status word
  with interrupt request. Assumes a synchronous host port: one-cycle write
  and read strobes with address, all synchronous to i_clk.
*/
// Operation
// RL1: A byte is latched when the host write or the DMA grant ends.
// RL2: The latch loads the port buffer and starts the strobe timer.
// RL3: After a 1 us settle time the port strobe goes low for 1 us.
// RL4: At strobe end the timer stops and waits for the next byte.
// RL5: Reading the port 1 data register returns the last latched byte.
// RL6: Port 2 has the same buffer, timer and read-back on its own.
// RL7: Selected peripheral conditions of both ports raise the request.
// RL8: Each port's configuration register selects its conditions.
// RL9: Both configuration registers are host writable and readable.
// RL10: A selected condition is latched and then requests an interrupt.
// RL11: A status read gives latched causes and live lines in one word.
// RL12: A status read clears the causes except bit 0, and bit 15.
// RL13: Bit 15 is set whenever bit 0, 6, 7, 13 or 14 is set.
// RL14: With its enable set, a busy rising edge raises an interrupt.
// RL15: Without master enable, status records but no request is made.
// RL16: The writer waits for the strobe to end before the next byte.
`timescale 1ns/1ps
`include "hcp_consts.svh"

module hcp_top
#(
  parameter int SETTLE_CYC = `HCP_SETTLE_CYC,
  parameter int STROBE_CYC = `HCP_STROBE_CYC
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Host register port
  input  wire hcp_pkg::hcp_addr_t i_addr,
  input  wire hcp_pkg::hcp_byte_t i_wdata,
  input  wire logic             i_host_write_pulse,
  input  wire logic             i_rd,
  output logic                  o_rvalid,
  output hcp_pkg::hcp_word_t    o_rdata,
  // DMA
  input  wire logic [1:0]       i_dma_grant_port,
  input  wire hcp_pkg::hcp_byte_t i_dma_data,
  input  wire logic             i_dma_irq_pending,
  // Peripheral status per port: sel, paper, busy, fault, ack
  input  wire logic [1:0]       i_sel,
  input  wire logic [1:0]       i_paper_empty,
  input  wire logic [1:0]       i_busy,
  input  wire logic [1:0]       i_fault,
  input  wire logic [1:0]       i_ack,
  // Peripheral outputs and host interrupt request
  output hcp_pkg::hcp_byte_t    o_p1_data,
  output hcp_pkg::hcp_byte_t    o_p2_data,
  output logic [1:0]            o_port_data_strobe_n,
  output logic                  o_irq
);
  import hcp_pkg::*;

  // The 8-bit timers cannot serve counts outside 1..255
  if (SETTLE_CYC < 1 || STROBE_CYC < 1 || SETTLE_CYC > 255
      || STROBE_CYC > 255)
  begin : g_bad_timing
    $error("hcp_top: timing counts out of range");
  end

  hcp_byte_t data_r [2];
  hcp_byte_t cfg_r  [2];
  hcp_state_e st_r  [2];
  logic [7:0] cnt_r [2];
  logic [1:0] wr_d_r, dack_d_r, busy_d_r, ack_d_r;
  logic [1:0] busy_ip_r, ack_ip_r, ack_seen_r;
  logic [1:0] wr_port, latch;
  logic       st_rd;

  function automatic logic is_port_wr(input hcp_addr_t a);
    is_port_wr = (a == `HCP_OFS_P1_DATA) || (a == `HCP_OFS_P2_DATA);
  endfunction

  assign wr_port[0] = i_host_write_pulse && i_addr == `HCP_OFS_P1_DATA;
  assign wr_port[1] = i_host_write_pulse && i_addr == `HCP_OFS_P2_DATA;
  assign st_rd      = i_rd && i_addr == `HCP_OFS_STATUS;

  // Trailing-edge detect of write or grant; data held for capture
  hcp_byte_t wdat_r [2];
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_d_r   <= 2'h0;
      dack_d_r <= 2'h0;
      wdat_r[0] <= `HCP_DATA_RESET;
      wdat_r[1] <= `HCP_DATA_RESET;
    end
    else
    begin
      wr_d_r   <= wr_port;
      dack_d_r <= i_dma_grant_port;
      for (int p = 0; p < 2; p++)
        if (wr_port[p] || (i_dma_grant_port[p] && cfg_r[p][`HCP_CFG_DMA_EN]))
          wdat_r[p] <= wr_port[p] ? i_wdata : i_dma_data;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_port
    // Host write in non-DMA mode, grant release in DMA mode
    assign latch[g] = cfg_r[g][`HCP_CFG_DMA_EN]
                    ? (dack_d_r[g] && !i_dma_grant_port[g])
                    : (wr_d_r[g] && !wr_port[g]); // RL1

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
      if (!i_nrst)
        data_r[g] <= `HCP_DATA_RESET;
      else if (latch[g])
        data_r[g] <= wdat_r[g]; // RL2 RL6
    end

    // A new byte mid-sequence restarts the settle time
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
      if (!i_nrst)
      begin
        st_r[g]  <= HCP_IDLE;
        cnt_r[g] <= 8'h00;
        o_port_data_strobe_n[g] <= 1'b1;
      end
      else if (latch[g])
      begin
        st_r[g]  <= HCP_SETTLE; // RL2
        cnt_r[g] <= 8'h00;
        o_port_data_strobe_n[g] <= 1'b1;
      end
      else
      begin
        case (st_r[g])
          HCP_IDLE:
            cnt_r[g] <= 8'h00;
          HCP_SETTLE:
            if (cnt_r[g] == 8'(SETTLE_CYC - 1))
            begin
              st_r[g]  <= HCP_STROBE; // RL3
              cnt_r[g] <= 8'h00;
              o_port_data_strobe_n[g] <= 1'b0;
            end
            else
              cnt_r[g] <= cnt_r[g] + 8'h01;
          HCP_STROBE:
            if (cnt_r[g] == 8'(STROBE_CYC - 1))
            begin
              st_r[g]  <= HCP_IDLE; // RL4
              cnt_r[g] <= 8'h00;
              o_port_data_strobe_n[g] <= 1'b1;
            end
            else
              cnt_r[g] <= cnt_r[g] + 8'h01;
          default:
          begin
            st_r[g]  <= HCP_IDLE;
            cnt_r[g] <= 8'h00;
            o_port_data_strobe_n[g] <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_p1_data <= `HCP_DATA_RESET;
      o_p2_data <= `HCP_DATA_RESET;
    end
    else
    begin
      o_p1_data <= data_r[0];
      o_p2_data <= data_r[1];
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_r[0] <= `HCP_CFG_RESET;
      cfg_r[1] <= `HCP_CFG_RESET;
    end
    else if (i_host_write_pulse && !is_port_wr(i_addr))
    begin
      if (i_addr == `HCP_OFS_P1_CFG)
        cfg_r[0] <= i_wdata; // RL9
      if (i_addr == `HCP_OFS_P2_CFG)
        cfg_r[1] <= i_wdata; // RL9
    end
  end

  // Interrupt causes; a new event beats the read clear
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      busy_d_r   <= 2'h0;
      ack_d_r    <= 2'h0;
      busy_ip_r  <= 2'h0;
      ack_ip_r   <= 2'h0;
      ack_seen_r <= 2'h0;
    end
    else
    begin
      busy_d_r <= i_busy;
      ack_d_r  <= i_ack;
      for (int p = 0; p < 2; p++)
      begin
        if (i_busy[p] && !busy_d_r[p] && cfg_r[p][`HCP_CFG_BUSY_EDGE])
          busy_ip_r[p] <= 1'b1; // RL8 RL10 RL14
        else if (st_rd)
          busy_ip_r[p] <= 1'b0; // RL12
        if (i_ack[p] && !ack_d_r[p] && cfg_r[p][`HCP_CFG_ACK_EN])
          ack_ip_r[p] <= 1'b1; // RL8 RL10
        else if (st_rd)
          ack_ip_r[p] <= 1'b0; // RL12
        if (i_ack[p] && !ack_d_r[p])
          ack_seen_r[p] <= 1'b1;
        else if (st_rd)
          ack_seen_r[p] <= 1'b0; // RL12
      end
    end
  end

  hcp_word_t status;
  logic      mip;
  always_comb
  begin
    status = 16'h0000;
    status[`HCP_ST_DMA_IP] = i_dma_irq_pending;
    status[`HCP_ST_P1_BASE +: 7] = {busy_ip_r[0], ack_ip_r[0], ack_seen_r[0],
      i_fault[0], i_busy[0], i_paper_empty[0], i_sel[0]}; // RL11
    status[`HCP_ST_P2_BASE +: 7] = {busy_ip_r[1], ack_ip_r[1], ack_seen_r[1],
      i_fault[1], i_busy[1], i_paper_empty[1], i_sel[1]}; // RL11
    mip = status[0] | status[6] | status[7] | status[13] | status[14];
    status[`HCP_ST_MIP] = mip; // RL13
  end

  // Request gated per port by its master enable
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_irq <= 1'b0;
    else
      o_irq <= i_dma_irq_pending
        | ((busy_ip_r[0] | ack_ip_r[0]) & cfg_r[0][`HCP_CFG_MASTER_EN])
        | ((busy_ip_r[1] | ack_ip_r[1])
           & cfg_r[1][`HCP_CFG_MASTER_EN]); // RL7 RL15
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 16'h0000;
    end
    else
    begin
      o_rvalid <= i_rd;
      if (i_rd)
        case (i_addr)
          `HCP_OFS_P1_DATA: o_rdata <= {8'h00, data_r[0]}; // RL5
          `HCP_OFS_P2_DATA: o_rdata <= {8'h00, data_r[1]}; // RL6
          `HCP_OFS_P1_CFG:  o_rdata <= {8'h00, cfg_r[0]};  // RL9
          `HCP_OFS_P2_CFG:  o_rdata <= {8'h00, cfg_r[1]};  // RL9
          `HCP_OFS_STATUS:  o_rdata <= status;             // RL11
          default:          o_rdata <= 16'h0000;
        endcase
    end
  end
endmodule

// ==== sim/hcp_checker.sv ====
/*
  Pin-level assertions for the hard copy port block.
  Assumes a bind into hcp_top that hands on its two counts.
*/
`timescale 1ns/1ps
module hcp_checker
#(
  parameter int SETTLE_CYC = 20,
  parameter int STROBE_CYC = 20
)
(
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_nrst,
  // Host side
  input wire hcp_pkg::hcp_addr_t i_addr,
  input wire hcp_pkg::hcp_byte_t i_wdata,
  input wire logic               i_host_write_pulse,
  input wire logic               i_rd,
  input wire logic               i_dma_irq_pending,
  input wire logic               o_rvalid,
  input wire hcp_pkg::hcp_word_t o_rdata,
  input wire logic               o_irq,
  // Peripheral side
  input wire logic [1:0]         i_sel,
  input wire logic [1:0]         i_paper_empty,
  input wire logic [1:0]         i_busy,
  input wire logic [1:0]         i_fault,
  input wire hcp_pkg::hcp_byte_t o_p1_data,
  input wire hcp_pkg::hcp_byte_t o_p2_data,
  input wire logic [1:0]         o_port_data_strobe_n
);
  import hcp_pkg::*;
  localparam int LOW_AT = SETTLE_CYC + 1;
  logic [7:0] low_cnt_r;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // Counted rather than unrolled, so long strobes stay cheap
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      low_cnt_r <= 8'h00;
    else if (o_port_data_strobe_n[1])
      low_cnt_r <= 8'h00;
    else
      low_cnt_r <= low_cnt_r + 8'h01;
  end
  sequence s_p1_latch;
    $fell(i_host_write_pulse) && i_addr == 4'h6;
  endsequence
  sequence s_p1_strobe;
    ##LOW_AT !o_port_data_strobe_n[0] ##STROBE_CYC o_port_data_strobe_n[0];
  endsequence
  a_p1_byte_latch:
    assert property (s_p1_latch |-> ##2 o_p1_data == $past(i_wdata, 3))
    else $error("port 1 byte not latched");
  a_p1_strobe_time:
    assert property (s_p1_latch |-> s_p1_strobe)
    else $error("port 1 strobe timing wrong");
  a_p2_strobe_len:
    assert property ($rose(o_port_data_strobe_n[1]) |->
      low_cnt_r == STROBE_CYC)
    else $error("port 2 strobe length wrong");
  a_p1_read_back:
    assert property (i_rd && i_addr == 4'h6 |=>
      o_rvalid && o_rdata == {8'h00, $past(o_p1_data)})
    else $error("port 1 read back wrong");
  a_p2_read_back:
    assert property (i_rd && i_addr == 4'h4 |=>
      o_rvalid && o_rdata == {8'h00, $past(o_p2_data)})
    else $error("port 2 read back wrong");
  a_status_live:
    assert property (i_rd && i_addr == 4'hE |=> o_rdata[4:0] == $past(
      {i_fault[0], i_busy[0], i_paper_empty[0], i_sel[0], i_dma_irq_pending}))
    else $error("live status bits wrong");
  a_master_pending:
    assert property (o_rvalid && $past(i_addr) == 4'hE |->
      o_rdata[15] == |{o_rdata[14:13], o_rdata[7:6], o_rdata[0]})
    else $error("summary bit wrong");
  a_dma_irq:
    assert property (i_dma_irq_pending |=> o_irq)
    else $error("dma pending gave no request");
endmodule
bind hcp_top hcp_checker #(.SETTLE_CYC(SETTLE_CYC), .STROBE_CYC(STROBE_CYC))
  u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_host_write_pulse(i_host_write_pulse), .i_rd(i_rd),
    .i_dma_irq_pending(i_dma_irq_pending), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_sel(i_sel),
    .i_paper_empty(i_paper_empty), .i_busy(i_busy), .i_fault(i_fault),
    .o_p1_data(o_p1_data), .o_p2_data(o_p2_data),
    .o_port_data_strobe_n(o_port_data_strobe_n));

// ==== sim/hcp_printer_model.sv ====
/*
  Printer model: busy after each strobe, then a short acknowledge.
  Assumes the active-low strobes of the hard copy block.
*/
`timescale 1ns/1ps
module hcp_printer_model
#(
  parameter int BUSY = 6
)
(
  // Clock and strobes
  input wire logic       i_clk,
  input wire logic [1:0] i_strobe_n,
  // Status lines
  output logic     [1:0] o_busy,
  output logic     [1:0] o_ack
);
  int cnt [2] = '{0, 0};
  always @(posedge i_clk)
    for (int p = 0; p < 2; p++)
      if (i_strobe_n[p] === 1'b0)
        cnt[p] <= 1;
      else if (cnt[p] != 0)
        cnt[p] <= (cnt[p] == BUSY + 2) ? 0 : cnt[p] + 1;
  always_comb
    for (int p = 0; p < 2; p++)
    begin
      o_busy[p] = cnt[p] inside {[1:BUSY]};
      o_ack[p] = cnt[p] > BUSY;
    end
endmodule

// ==== sim/test_hcp_top.sv ====
/*
  Self-checking bench for the hard copy port block.
  Assumes the design, checker bind and printer model compile first.
*/
`timescale 1ns/1ps
module test_hcp_top;
  import hcp_pkg::*;
  localparam int STB = 2;
  localparam hcp_byte_t CFGS [4] = '{8'h02, 8'h05, 8'h06, 8'h07};
  logic       i_clk = 1'b0, i_nrst = 1'b0, i_rd = 1'b0, o_rvalid, o_irq;
  logic       i_host_write_pulse = 1'b0, i_dma_irq_pending = 1'b0;
  logic [1:0] i_dma_grant_port = 2'h0, i_sel = 2'h3, i_busy, i_ack;
  logic [1:0] i_paper_empty = 2'h0, i_fault = 2'h0, o_port_data_strobe_n;
  logic [1:0] seen = 2'h0, aip = 2'h0, bip = 2'h0;
  hcp_addr_t  i_addr = 4'h0;
  hcp_byte_t  i_wdata = 8'h00, i_dma_data = 8'h00, o_p1_data, o_p2_data;
  hcp_byte_t  b0, b1, cf [2];
  hcp_word_t  o_rdata;
  int         seed = 95, fail_count = 0, n_checks = 0;

  always #25 i_clk = ~i_clk;
  hcp_top #(.SETTLE_CYC(3), .STROBE_CYC(STB)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_host_write_pulse(i_host_write_pulse), .i_rd(i_rd),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .i_dma_grant_port(i_dma_grant_port), .i_dma_data(i_dma_data),
    .i_dma_irq_pending(i_dma_irq_pending), .i_sel(i_sel),
    .i_paper_empty(i_paper_empty), .i_busy(i_busy), .i_fault(i_fault),
    .i_ack(i_ack), .o_p1_data(o_p1_data), .o_p2_data(o_p2_data),
    .o_port_data_strobe_n(o_port_data_strobe_n), .o_irq(o_irq));
  hcp_printer_model peer (.i_clk(i_clk), .i_strobe_n(o_port_data_strobe_n),
    .o_busy(i_busy), .o_ack(i_ack));

  task automatic chk(input hcp_word_t got, input hcp_word_t exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input hcp_addr_t a, input hcp_byte_t d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_host_write_pulse <= 1'b1;
    @(posedge i_clk);
    i_host_write_pulse <= 1'b0;
    @(posedge i_clk);
    if (a[3])
      cf[a[1]] = d;
  endtask
  task automatic rd(input hcp_addr_t a, input hcp_word_t e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
    chk({15'h0000, o_rvalid}, 16'h0001);
  endtask
  // Model: one byte went out on port p
  task automatic sent(input int p);
    seen[p] = 1'b1;
    aip[p] = aip[p] | cf[p][2];
    bip[p] = bip[p] | cf[p][1];
  endtask
  task automatic settle(input logic [1:0] m);
    int n [2];
    n = '{0, 0};
    repeat (45)
    begin
      @(negedge i_clk);
      for (int p = 0; p < 2; p++)
        n[p] += int'(o_port_data_strobe_n[p] === 1'b0);
    end
    for (int p = 0; p < 2; p++)
      chk(16'(n[p]), m[p] ? 16'(STB) : 16'h0000);
  endtask
  function automatic hcp_word_t exp_st();
    hcp_word_t w;
    w = {15'h0000, i_dma_irq_pending};
    for (int q = 0; q < 2; q++)
      w[q*7+1 +: 7] = {bip[q], aip[q], seen[q], i_fault[q], i_busy[q],
        i_paper_empty[q], i_sel[q]};
    w[15] = |{w[14:13], w[7:6], w[0]};
    return w;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    $display("unexpected at %0t: watchdog ran out", $time);
    stop_test();
  end
  initial
  begin
    cf = '{8'h00, 8'h00};
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3)
    begin
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      wr(4'h6, b0);
      wr(4'h4, b1);
      sent(0);
      sent(1);
      settle(2'b11);
      chk({8'h00, o_p1_data}, {8'h00, b0});
      chk({8'h00, o_p2_data}, {8'h00, b1});
      rd(4'h6, {8'h00, b0});
      rd(4'h4, {8'h00, b1});
    end
    $display("test data path done");
    for (int p = 0; p < 2; p++)
    begin
      wr(p ? 4'hA : 4'h8, 8'h08);
      b1 = 8'($random(seed));
      @(posedge i_clk);
      i_dma_data <= b1;
      i_dma_grant_port <= p ? 2'b10 : 2'b01;
      @(posedge i_clk);
      i_dma_grant_port <= 2'b00;
      sent(p);
      settle(p ? 2'b10 : 2'b01);
      rd(p ? 4'h4 : 4'h6, {8'h00, b1});
      wr(p ? 4'hA : 4'h8, 8'h00);
    end
    $display("test dma done");
    rd(4'hE, exp_st());
    {seen, aip, bip} = 6'h00;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        wr(p ? 4'hA : 4'h8, CFGS[c]);
        {i_sel, i_fault, i_paper_empty} <= 6'($random(seed));
        wr(p ? 4'h4 : 4'h6, 8'($random(seed)));
        sent(p);
        settle(p ? 2'b10 : 2'b01);
        chk({15'h0000, o_irq}, {15'h0000, CFGS[c][0] & |CFGS[c][2:1]});
        rd(4'hE, exp_st());
        {seen, aip, bip} = 6'h00;
        rd(4'hE, exp_st());
      end
    $display("test interrupts done");
    @(posedge i_clk);
    i_dma_irq_pending <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk({15'h0000, o_irq}, 16'h0001);
    rd(4'hE, exp_st());
    rd(4'hE, exp_st());
    @(posedge i_clk);
    i_dma_irq_pending <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk({15'h0000, o_irq}, 16'h0000);
    repeat (3)
    begin
      b0 = 8'($random(seed));
      wr(4'h8, b0);
      rd(4'h8, {8'h00, b0});
      wr(4'hA, ~b0);
      rd(4'hA, {8'h00, ~b0});
      wr(4'h2, b0);
      rd(4'h2, 16'h0000);
    end
    $display("test registers done");
    stop_test();
  end
endmodule
